// ### cpu_space_consts.vh
// Constants for the special address-space cycle block: bus codes,
// vectors and register offsets. Included by cpu_space_cycle_logic.v.
`ifndef CPU_SPACE_CONSTS_VH
`define CPU_SPACE_CONSTS_VH

// Function code of the special processor space
`define FC_CPU_SPACE 3'h7
// Type field codes on address bits 19..16
`define TYPE_BREAKPOINT_INSTRUCTION 4'h0
`define TYPE_MODULE 4'h1
`define TYPE_COPROC 4'h2
`define TYPE_IACK 4'hf
// Vectors
`define AUTOVEC_BASE 8'h18
`define SPURIOUS_VEC 8'h18
// Highest priority level, edge triggered
`define LEVEL_NMI 3'h7
// Size acknowledge codes, bit 1 = 16-bit lane, bit 0 = 8-bit lane
`define ACK_BYTE 2'h1
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_EN 8'h08
`define REG_INT_CLR 8'h0c
`define REG_VECTOR 8'h10
`define REG_BREAKPOINT_INSTRUCTION_WORD 8'h14
`define REG_CP_DATA 8'h18
`define REG_STATE 8'h1c
// Control reset value: mask 7, full address width
`define CTRL_RESET 4'h7
// Status bit positions
`define ST_IACK 0
`define ST_AUTOVEC 1
`define ST_SPURIOUS 2
`define ST_BREAKPOINT_INSTRUCTION 3
`define ST_ILLEGAL 4
`define ST_CP_DONE 5
`define ST_CP_BUS_ERROR_INPUT 6
`define ST_RETRY 7
`define ST_BITS 8

`endif

// ### cpu_space_cycle_logic.v
// Special address-space cycle generator: interrupt, breakpoint and
// coprocessor cycles, with an AHB-Lite register slave.
// Assumes one bus controller that runs each cycle while cyc_req is high
// and returns one termination (ack, autovector, bus error) per cycle.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_space_consts.vh"

module cpu_space_cycle_logic (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  output wire irq,
  input wire [2:0] int_priority_request_lines_n,
  input wire insn_boundary,
  input wire higher_exc_pending,
  input wire breakpoint_instruction,
  input wire [2:0] breakpoint_instruction_number,
  input wire cp_request,
  input wire cp_module_space,
  input wire [2:0] coprocessor_identifier,
  input wire [7:0] cp_reg_select,
  input wire cp_write,
  input wire [31:0] cp_wdata,
  output wire cyc_req,
  output reg cyc_read,
  output reg [2:0] function_code_outputs,
  output reg [31:0] cyc_addr,
  output reg [31:0] cyc_wdata,
  input wire [1:0] size_acknowledge,
  input wire autovector_request,
  input wire bus_error_input,
  input wire halt_input,
  input wire [31:0] cyc_rdata,
  output reg int_take,
  output reg [7:0] int_vector,
  output reg breakpoint_instruction_word_valid,
  output reg [15:0] breakpoint_instruction_word,
  output reg illegal_insn,
  output reg cp_done,
  output reg cp_bus_error,
  output reg [31:0] cp_rdata,
  output wire busy
);

  localparam S_IDLE = 3'd0;
  localparam S_IACK = 3'd1;
  localparam S_BREAKPOINT_INSTRUCTION = 3'd2;
  localparam S_BKPT2 = 3'd3;
  localparam S_CP = 3'd4;
  localparam S_RETRY = 3'd5;

  reg [2:0] state_r;
  reg [2:0] resume_r;
  reg [2:0] ipl_meta_r;
  reg [2:0] ipl_sync_r;
  reg [2:0] level_prev_r;
  reg nmi_edge_r;
  reg pend_r;
  reg [2:0] pend_level_r;
  reg [2:0] ack_level_r;
  reg [3:0] ctrl_r;
  reg [`ST_BITS-1:0] status_r;
  reg [`ST_BITS-1:0] int_en_r;
  reg [7:0] last_vec_r;
  reg [15:0] breakpoint_instruction_word_r;
  reg [7:0] breakpoint_instruction_hi_r;
  reg dp_wr_r;
  reg dp_act_r;
  reg [7:0] dp_addr_r;
  reg [31:0] rdata_mux;
  reg [`ST_BITS-1:0] ev_set;

  wire [2:0] mask = ctrl_r[2:0];
  wire reduced = ctrl_r[3];
  // level is the inverted request lines
  wire [2:0] level_now = ~ipl_sync_r;
  wire term_any = (|size_acknowledge) | autovector_request | bus_error_input;
  wire cycle_state = (state_r == S_IACK) || (state_r == S_BREAKPOINT_INSTRUCTION) ||
                     (state_r == S_BKPT2) || (state_r == S_CP);
  wire retry = bus_error_input & halt_input;
  // Upper address bits forced high, only A23..A20 on the reduced bus
  wire [11:0] upper_ones = reduced ? 12'h00f : 12'hfff;

  assign cyc_req = cycle_state;
  assign busy = (state_r != S_IDLE);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(status_r & int_en_r);

  // Request lines: second stage is the only reader of the first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ipl_meta_r <= 3'h7;
      ipl_sync_r <= 3'h7;
      level_prev_r <= 3'h0;
      nmi_edge_r <= 1'b0;
    end else begin
      ipl_meta_r <= int_priority_request_lines_n;
      ipl_sync_r <= ipl_meta_r;
      level_prev_r <= level_now;
      nmi_edge_r <= (level_now == `LEVEL_NMI) && (level_prev_r != `LEVEL_NMI);
    end
  end

  // pending on level above mask, or level 7 transition
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pend_level_r <= 3'h0;
    end else if (nmi_edge_r || (level_now > mask && level_now != `LEVEL_NMI)) begin
      pend_r <= 1'b1;
      pend_level_r <= nmi_edge_r ? `LEVEL_NMI : level_now;
    end else if (state_r == S_IDLE && pend_r && insn_boundary && !higher_exc_pending) begin
      pend_r <= 1'b0;
    end else if (!nmi_edge_r && pend_level_r != `LEVEL_NMI && level_now <= mask) begin
      pend_r <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      resume_r <= S_IDLE;
      ack_level_r <= 3'h0;
      cyc_read <= 1'b1;
      function_code_outputs <= 3'h0;
      cyc_addr <= 32'h0;
      cyc_wdata <= 32'h0;
      int_take <= 1'b0;
      int_vector <= 8'h0;
      breakpoint_instruction_word_valid <= 1'b0;
      breakpoint_instruction_word <= 16'h0;
      illegal_insn <= 1'b0;
      cp_done <= 1'b0;
      cp_bus_error <= 1'b0;
      cp_rdata <= 32'h0;
      breakpoint_instruction_hi_r <= 8'h0;
      last_vec_r <= 8'h0;
      breakpoint_instruction_word_r <= 16'h0;
      ev_set <= {`ST_BITS{1'b0}};
    end else begin
      int_take <= 1'b0;
      breakpoint_instruction_word_valid <= 1'b0;
      illegal_insn <= 1'b0;
      cp_done <= 1'b0;
      cp_bus_error <= 1'b0;
      ev_set <= {`ST_BITS{1'b0}};
      case (state_r)
        S_IDLE: begin
          // interrupt waits for boundary and higher exceptions
          if (pend_r && insn_boundary && !higher_exc_pending) begin
            state_r <= S_IACK;
            ack_level_r <= pend_level_r;
            cyc_read <= 1'b1;
            function_code_outputs <= `FC_CPU_SPACE;
            cyc_addr <= {upper_ones, `TYPE_IACK, 12'hfff, pend_level_r, 1'b1};
          end else if (breakpoint_instruction) begin
            state_r <= S_BREAKPOINT_INSTRUCTION;
            cyc_read <= 1'b1;
            function_code_outputs <= `FC_CPU_SPACE;
            cyc_addr <= {12'h000, `TYPE_BREAKPOINT_INSTRUCTION, 11'h000, breakpoint_instruction_number, 2'b00};
          end else if (cp_request) begin
            state_r <= S_CP;
            cyc_read <= ~cp_write;
            cyc_wdata <= cp_wdata;
            function_code_outputs <= `FC_CPU_SPACE;
            // MMU space uses an 8-bit select
            if (cp_module_space) begin
              cyc_addr <= {12'h000, `TYPE_MODULE, 8'h00, cp_reg_select};
            end else begin
              cyc_addr <= {12'h000, `TYPE_COPROC, coprocessor_identifier, 7'h00, cp_reg_select[5:0]};
            end
          end
        end
        S_IACK: begin
          if (retry) begin
            // halt with bus error reruns the acknowledge
            resume_r <= S_IACK;
            state_r <= S_RETRY;
          end else if (term_any) begin
            state_r <= S_IDLE;
            int_take <= 1'b1;
            ev_set[`ST_IACK] <= 1'b1;
            if (bus_error_input) begin
              int_vector <= `SPURIOUS_VEC;
              last_vec_r <= `SPURIOUS_VEC;
              ev_set[`ST_SPURIOUS] <= 1'b1;
            end else if (autovector_request) begin
              // data bus ignored, level plus 24
              int_vector <= `AUTOVEC_BASE + {5'h00, ack_level_r};
              last_vec_r <= `AUTOVEC_BASE + {5'h00, ack_level_r};
              ev_set[`ST_AUTOVEC] <= 1'b1;
            end else begin
              // vector from low byte of data bus
              int_vector <= cyc_rdata[7:0];
              last_vec_r <= cyc_rdata[7:0];
            end
          end
        end
        S_BREAKPOINT_INSTRUCTION: begin
          if (bus_error_input) begin
            state_r <= S_IDLE;
            illegal_insn <= 1'b1;
            ev_set[`ST_ILLEGAL] <= 1'b1;
          end else if (size_acknowledge == `ACK_BYTE) begin
            // byte port, fetch the second byte
            breakpoint_instruction_hi_r <= cyc_rdata[31:24];
            cyc_addr[0] <= 1'b1;
            state_r <= S_RETRY;
            resume_r <= S_BKPT2;
          end else if (|size_acknowledge) begin
            state_r <= S_IDLE;
            breakpoint_instruction_word <= cyc_rdata[31:16];
            breakpoint_instruction_word_r <= cyc_rdata[31:16];
            breakpoint_instruction_word_valid <= 1'b1;
            ev_set[`ST_BREAKPOINT_INSTRUCTION] <= 1'b1;
          end
        end
        S_BKPT2: begin
          if (bus_error_input) begin
            state_r <= S_IDLE;
            illegal_insn <= 1'b1;
            ev_set[`ST_ILLEGAL] <= 1'b1;
          end else if (|size_acknowledge) begin
            state_r <= S_IDLE;
            breakpoint_instruction_word <= {breakpoint_instruction_hi_r, cyc_rdata[31:24]};
            breakpoint_instruction_word_r <= {breakpoint_instruction_hi_r, cyc_rdata[31:24]};
            breakpoint_instruction_word_valid <= 1'b1;
            ev_set[`ST_BREAKPOINT_INSTRUCTION] <= 1'b1;
          end
        end
        S_CP: begin
          if (bus_error_input) begin
            state_r <= S_IDLE;
            cp_bus_error <= 1'b1;
            ev_set[`ST_CP_BUS_ERROR_INPUT] <= 1'b1;
          end else if (|size_acknowledge) begin
            state_r <= S_IDLE;
            cp_done <= 1'b1;
            cp_rdata <= cyc_rdata;
            ev_set[`ST_CP_DONE] <= 1'b1;
          end
        end
        S_RETRY: begin
          // One idle cycle so the controller sees a fresh cycle
          if (resume_r == S_IACK) begin
            ev_set[`ST_RETRY] <= 1'b1;
          end
          state_r <= resume_r;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready) begin
      dp_act_r <= hsel & htrans[1];
      dp_wr_r <= hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  wire wr_en = dp_act_r & dp_wr_r;
  wire [`ST_BITS-1:0] clr_bits = (wr_en && dp_addr_r == `REG_INT_CLR) ? hwdata[`ST_BITS-1:0] : {`ST_BITS{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET;
      int_en_r <= {`ST_BITS{1'b0}};
      status_r <= {`ST_BITS{1'b0}};
    end else begin
      if (wr_en && dp_addr_r == `REG_CTRL) begin
        ctrl_r <= hwdata[3:0];
      end
      if (wr_en && dp_addr_r == `REG_INT_EN) begin
        int_en_r <= hwdata[`ST_BITS-1:0];
      end
      // Set beats clear in the same cycle
      status_r <= (status_r & ~clr_bits) | ev_set;
    end
  end

  always @* begin
    rdata_mux = 32'h0;
    case (dp_addr_r)
      `REG_CTRL: rdata_mux = {28'h0, ctrl_r};
      `REG_STATUS: rdata_mux = {24'h0, status_r};
      `REG_INT_EN: rdata_mux = {24'h0, int_en_r};
      `REG_VECTOR: rdata_mux = {20'h0, pend_r, pend_level_r, last_vec_r};
      `REG_BREAKPOINT_INSTRUCTION_WORD: rdata_mux = {16'h0, breakpoint_instruction_word_r};
      `REG_CP_DATA: rdata_mux = cp_rdata;
      `REG_STATE: rdata_mux = {29'h0, state_r};
      default: rdata_mux = 32'h0;
    endcase
  end

  // Unmapped and write-only offsets read as zero
  assign hrdata = (dp_act_r && !dp_wr_r) ? rdata_mux : 32'h0;

endmodule // cpu_space_cycle_logic
`default_nettype wire

// ### cpu_space_cycle_logic_assertions.sv
// Checker for the special-space cycle block, one clock domain.
// Bound to cpu_space_cycle_logic; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module space_cycle_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic busy,
  input wire logic cyc_req,
  input wire logic cyc_read,
  input wire logic [2:0] function_code_outputs,
  input wire logic [31:0] cyc_addr,
  input wire logic [1:0] size_acknowledge,
  input wire logic autovector_request,
  input wire logic bus_error_input,
  input wire logic halt_input,
  input wire logic int_take,
  input wire logic [7:0] int_vector,
  input wire logic breakpoint_instruction,
  input wire logic [2:0] breakpoint_instruction_number,
  input wire logic insn_boundary,
  input wire logic breakpoint_instruction_word_valid,
  input wire logic illegal_insn
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic iack;
  logic bk;
  assign iack = cyc_req && cyc_addr[19:16] == 4'hf;
  assign bk = cyc_req && cyc_addr[19:16] == 4'h0;
  property p_fc;
    cyc_req |-> function_code_outputs == 3'h7 && (!iack || cyc_read);
  endproperty
  a_fc: assert property (p_fc) else $error("bad function code");
  property p_iack_addr;
    iack |-> cyc_addr[23:20] == 4'hf && cyc_addr[15:4] == 12'hfff && cyc_addr[0];
  endproperty
  a_iack_addr: assert property (p_iack_addr) else $error("bad acknowledge address");
  property p_autovector_request;
    iack && autovector_request && !bus_error_input |=> int_take && int_vector == 8'h18 + $past(cyc_addr[3:1]);
  endproperty
  a_autovector_request: assert property (p_autovector_request) else $error("bad autovector");
  property p_spur;
    iack && bus_error_input && !halt_input |=> int_take && int_vector == 8'h18;
  endproperty
  a_spur: assert property (p_spur) else $error("bad spurious vector");
  property p_retry;
    iack && bus_error_input && halt_input |=> !int_take && !cyc_req ##1 cyc_req && cyc_addr == $past(cyc_addr, 2);
  endproperty
  a_retry: assert property (p_retry) else $error("no acknowledge retry");
  property p_bk_start;
    breakpoint_instruction && !busy && !insn_boundary |=> bk && cyc_addr[4:2] == $past(breakpoint_instruction_number);
  endproperty
  a_bk_start: assert property (p_bk_start) else $error("bad breakpoint cycle");
  property p_bk_byte;
    bk && size_acknowledge == 2'h1 && !cyc_addr[0] && !bus_error_input |=> !breakpoint_instruction_word_valid ##[1:4] bk && cyc_addr[0];
  endproperty
  a_bk_byte: assert property (p_bk_byte) else $error("no second byte cycle");
  property p_bk_err;
    bk && bus_error_input |=> illegal_insn && !breakpoint_instruction_word_valid;
  endproperty
  a_bk_err: assert property (p_bk_err) else $error("no illegal instruction");
  c_autovector_request: cover property (iack && autovector_request);
  c_retry: cover property (iack && bus_error_input && halt_input);
  c_byte: cover property (bk && size_acknowledge == 2'h1);
endmodule // space_cycle_checker
bind cpu_space_cycle_logic space_cycle_checker i_chk (.hclk, .hresetn, .busy, .cyc_req, .cyc_read,
  .function_code_outputs, .cyc_addr, .size_acknowledge, .autovector_request, .bus_error_input, .halt_input,
  .int_take, .int_vector, .breakpoint_instruction, .breakpoint_instruction_number, .insn_boundary, .breakpoint_instruction_word_valid, .illegal_insn);
`default_nettype wire

// ### space_responder.sv
// Far side: interrupt sources, debug hardware and coprocessors.
// Answers each special-space cycle after dly edges, as mode says.
`timescale 1ns/1ps
`default_nettype none
module space_responder (
  input wire logic clk,
  input wire logic cyc_req,
  input wire logic [31:0] cyc_addr,
  input wire logic [2:0] mode,
  input wire logic [1:0] dly,
  input wire logic [31:0] data,
  output logic [1:0] size_acknowledge = 2'h0,
  output logic autovector_request = 1'b0,
  output logic bus_error_input = 1'b0,
  output logic halt_input = 1'b0,
  output logic [31:0] cyc_rdata = 32'h0
);
  logic [2:0] cnt = 3'h0;
  logic retried = 1'b0;
  logic go;
  assign go = cyc_req && cnt == {1'b0, dly} && size_acknowledge == 2'h0 && !autovector_request && !bus_error_input;
  always @(posedge clk) begin
    cnt <= (cyc_req && !go) ? cnt + 3'h1 : 3'h0;
    size_acknowledge <= 2'h0;
    autovector_request <= 1'b0;
    bus_error_input <= 1'b0;
    halt_input <= 1'b0;
    // Released lane shows no stale value
    cyc_rdata <= ~cyc_rdata;
    if (go && (cyc_addr[19:16] == 4'hf || cyc_addr[19:16] < 4'h3)) begin
      retried <= mode == 3'h3 && !retried;
      case (mode)
        3'h0: size_acknowledge <= 2'h2;
        3'h2: bus_error_input <= 1'b1;
        3'h4: size_acknowledge <= 2'h1;
        3'h3: if (!retried) {bus_error_input, halt_input} <= 2'h3; else autovector_request <= 1'b1;
        default: autovector_request <= 1'b1;
      endcase
      // only a byte-port breakpoint moves its low byte to the top lane
      if (!mode[1]) cyc_rdata <= (cyc_addr[19:16] == 4'h0 && cyc_addr[0]) ? data << 8 : data;
    end
  end
endmodule // space_responder
`default_nettype wire

// ### tb_cpu_space_cycle_logic.sv
// Self-checking bench for the special-space cycle block.
// Drives bus and request pins; space_responder answers cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_space_cycle_logic;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, insn_boundary = 0, higher_exc_pending = 0, rd_ph = 0;
  logic breakpoint_instruction = 0, cp_request = 0, cp_module_space = 0, cp_write = 0;
  logic [31:0] haddr = '0, hwdata = '0, data = '0;
  logic [1:0] htrans = '0, dly = '0;
  logic [2:0] int_priority_request_lines_n = 3'h7, breakpoint_instruction_number = '0, coprocessor_identifier = '0, mode = '0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] cp_reg_select = '0;
  logic [7:0] top_a = 8'hff;
  wire hreadyout, irq, cyc_req, cyc_read, autovector_request, bus_error_input, halt_input, int_take;
  wire breakpoint_instruction_word_valid, illegal_insn, cp_done, cp_bus_error, busy, hresp;
  wire [2:0] function_code_outputs;
  wire [31:0] hrdata, cyc_addr, cyc_rdata, cp_rdata, cyc_wdata;
  wire [1:0] size_acknowledge;
  wire [7:0] int_vector;
  wire [15:0] breakpoint_instruction_word;
  int err_count = 0, checks = 0, n;
  logic [35:0] q[$];
  always #2.5 hclk = ~hclk;
  cpu_space_cycle_logic i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .int_priority_request_lines_n, .insn_boundary,
    .higher_exc_pending, .breakpoint_instruction, .breakpoint_instruction_number, .cp_request, .cp_module_space,
    .coprocessor_identifier, .cp_reg_select, .cp_write, .cp_wdata(data), .cyc_req, .cyc_read,
    .function_code_outputs, .cyc_addr, .cyc_wdata, .size_acknowledge, .autovector_request, .bus_error_input,
    .halt_input, .cyc_rdata, .int_take, .int_vector, .breakpoint_instruction_word_valid, .breakpoint_instruction_word, .illegal_insn, .cp_done,
    .cp_bus_error, .cp_rdata, .busy);
  space_responder i_far (.clk(hclk), .cyc_req, .cyc_addr, .mode, .dly, .data, .size_acknowledge,
    .autovector_request, .bus_error_input, .halt_input, .cyc_rdata);
  task stop_test;
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task got(input string what, input logic [35:0] seen);
    chk(what, seen, q.size() ? q.pop_front() : 'x);
  endtask
  task tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task timed_out;
    err_count++;
    stop_test;
  endtask
  task wait_idle;
    n = 0;
    do begin @(posedge hclk); n++; end while ((busy !== 1'b0 || n < 3) && n < 300);
    if (n >= 300) timed_out;
    tick(2);
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w) q.push_back({4'h4, d});
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd_ph <= 1'b0;
    if (n >= 50) timed_out;
  endtask
  task irq_run(input logic [2:0] lvl, input logic [2:0] md);
    logic [31:0] v;
    v = $urandom;
    data <= v;
    mode <= md;
    dly <= 2'($urandom);
    int_priority_request_lines_n <= ~lvl;
    higher_exc_pending <= 1'b1;
    insn_boundary <= 1'b1;
    tick(6);
    chk("busy", 36'(busy), 36'h0);
    q.push_back({28'h1, md == 3'h0 ? v[7:0] : md == 3'h2 ? 8'h18 : 8'h18 + 8'(lvl)});
    higher_exc_pending <= 1'b0;
    @(posedge hclk);
    insn_boundary <= 1'b0;
    int_priority_request_lines_n <= 3'h7;
    @(posedge hclk);
    chk("acknowledge address", 36'(cyc_addr), 36'({top_a, 8'hff, 12'hfff, lvl, 1'b1}));
    wait_idle;
  endtask
  task far_run(input logic bk, input logic [2:0] num, input logic [2:0] md);
    logic [31:0] v;
    logic [7:0] s;
    v = $urandom;
    s = $urandom;
    data <= v;
    mode <= md;
    dly <= 2'($urandom);
    breakpoint_instruction <= bk;
    breakpoint_instruction_number <= num;
    cp_request <= !bk;
    coprocessor_identifier <= num;
    cp_module_space <= num == 3'h0;
    cp_reg_select <= s;
    cp_write <= v[0];
    if (bk) q.push_back(md == 3'h2 ? {4'h3, 32'h0} : {20'h2, v[31:16]});
    else q.push_back(md == 3'h2 ? {4'h6, 32'h0} : {4'h5, v});
    @(posedge hclk);
    breakpoint_instruction <= 1'b0;
    cp_request <= 1'b0;
    @(posedge hclk);
    chk("space cycle read", 36'(cyc_read), bk ? 36'h1 : 36'(!v[0]));
    if (bk) chk("breakpoint address", 36'(cyc_addr), 36'({num, 2'h0}));
    else if (num == 3'h0) chk("module space address", 36'(cyc_addr), 36'({24'h000100, s}));
    else chk("coprocessor address", 36'(cyc_addr), 36'({16'h0002, num, 7'h00, s[5:0]}));
    if (!bk) chk("coprocessor write data", 36'(cyc_wdata), 36'(v));
    wait_idle;
    if (md != 3'h2) ahb(1'b0, bk ? 32'h14 : 32'h18, bk ? {16'h0, v[31:16]} : v);
  endtask
  always @(posedge hclk) if (hresetn) begin
    if (rd_ph && hreadyout) got("register read", {4'h4, hrdata});
    if (rd_ph) chk("hresp", 36'(hresp), 36'h0);
    if (int_take) got("interrupt vector", {28'h1, int_vector});
    if (breakpoint_instruction_word_valid) got("breakpoint word", {20'h2, breakpoint_instruction_word});
    if (illegal_insn) got("illegal instruction", {4'h3, 32'h0});
    if (cp_done) got("coprocessor data", {4'h5, cp_rdata});
    if (cp_bus_error) got("coprocessor error", {4'h6, 32'h0});
  end
  initial begin
    void'($urandom(99));
    tick(16);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h7);
    ahb(1'b1, 32'h0, 32'h0);
    for (int l = 1; l < 8; l++) irq_run(3'(l), 3'((l - 1) % 4));
    ahb(1'b0, 32'h10, 32'h718);
    // Mask 5 on the reduced address variant
    ahb(1'b1, 32'h0, 32'hd);
    top_a = 8'h00;
    int_priority_request_lines_n <= ~3'h3;
    insn_boundary <= 1'b1;
    tick(6);
    chk("busy", 36'(busy), 36'h0);
    irq_run(3'h6, 3'h0);
    for (int b = 0; b < 8; b++) far_run(1'b1, 3'(b), b % 3 == 0 ? 3'h0 : b % 3 == 1 ? 3'h4 : 3'h2);
    for (int c = 0; c < 8; c++) far_run(1'b0, 3'(c), c == 5 ? 3'h2 : 3'h0);
    ahb(1'b0, 32'h04, 32'hff);
    ahb(1'b1, 32'h08, 32'h01);
    tick(1);
    chk("irq", 36'(irq), 36'h1);
    ahb(1'b1, 32'h08, 32'h00);
    tick(1);
    chk("irq", 36'(irq), 36'h0);
    ahb(1'b1, 32'h08, 32'h01);
    ahb(1'b1, 32'h0c, 32'hff);
    tick(1);
    chk("irq", 36'(irq), 36'h0);
    ahb(1'b1, 32'h04, 32'h5a);
    ahb(1'b0, 32'h04, 32'h00);
    ahb(1'b0, 32'h08, 32'h01);
    ahb(1'b0, 32'h40, 32'h00);
    ahb(1'b0, 32'h1c, 32'h00);
    tick(4);
    chk("results left", 36'(q.size()), 36'h0);
    stop_test;
  end
endmodule // tb_cpu_space_cycle_logic
`default_nettype wire
